/* hdl/lpo_params.svh */
`ifndef LPO_PARAMS_SVH
`define LPO_PARAMS_SVH

// Opcode fields of the instruction word.
`define LPO_OP_OR_LIT 8'h09
`define LPO_OP_OR_FILE 6'h04
`define LPO_OP_LDPTR1 10'h3b8
`define LPO_OP_LDPTR2 8'hf0
// Bit positions inside a file instruction.
`define LPO_BIT_DEST 9
`define LPO_BIT_ACC 8
// Highest address that uses indexed literal offset addressing.
`define LPO_IDX_MAX 8'h5f
// Low part of the access bank ends below 0x60 and maps to bank 0; upper addresses map to bank 0xf.
`define LPO_ACC_SPLIT 8'h60
`define LPO_ACC_HI_BANK 4'hf
// Reset values.
`define LPO_W_RST 8'h00
`define LPO_PTR_RST 12'h000
// Phases per instruction cycle.
`define LPO_PHASES 4

`endif

/* hdl/lpo_pkg.sv */
package lpo_pkg;
    typedef enum logic [1:0] {
        LPO_Q1 = 2'b00,
        LPO_Q2 = 2'b01,
        LPO_Q3 = 2'b10,
        LPO_Q4 = 2'b11
    } lpo_phase_t;

    typedef enum logic [1:0] {
        LPO_K_NONE = 2'b00,
        LPO_K_ORLIT = 2'b01,
        LPO_K_ORFILE = 2'b10,
        LPO_K_LDPTR = 2'b11
    } lpo_kind_t;
endpackage : lpo_pkg

/* hdl/lpo_addr_gen.sv */
`timescale 1ns/1ps
`include "lpo_params.svh"

// Forms the 12-bit data-memory address of a file operand.
module lpo_addr_gen (
    // Operand fields.
    input wire logic [7:0] faddr,
    input wire logic acc_sel,
    input wire logic [3:0] bank_sel,
    // Indexed mode and its base pointer.
    input wire logic ext_en,
    input wire logic [11:0] index_base,
    // Result.
    output logic [11:0] addr,
    output logic indexed
);
    always_comb begin
        indexed = 1'b0;
        if (acc_sel) begin
            addr = {bank_sel, faddr};
        end else if (ext_en && faddr <= `LPO_IDX_MAX) begin
            indexed = 1'b1;
            addr = 12'(index_base + {4'h0, faddr});
        end else if (faddr < `LPO_ACC_SPLIT) begin
            addr = {4'h0, faddr};
        end else begin
            addr = {`LPO_ACC_HI_BANK, faddr};
        end
    end
endmodule : lpo_addr_gen

/* hdl/lpo_core.sv */
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "lpo_params.svh"

module lpo_core
    import lpo_pkg::*;
#(
    parameter int NPTR = 3
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Program memory word, held stable for the whole instruction cycle.
    input wire logic [15:0] instr,
    // Mode inputs.
    input wire logic ext_en,
    input wire logic [3:0] bank_select_reg,
    // Data memory.
    input wire logic [7:0] dmem_rdata,
    output logic [11:0] dmem_addr,
    output logic dmem_re,
    output logic dmem_we,
    output logic [7:0] dmem_wdata,
    // Core state.
    output lpo_pkg::lpo_phase_t phase,
    output logic [7:0] wreg,
    output logic flag_n,
    output logic flag_z,
    output logic [11:0] indirect_pointer_reg0,
    output logic [11:0] indirect_pointer_reg1,
    output logic [11:0] indirect_pointer_reg2,
    output logic illegal
);
    import lpo_pkg::*;

    // The selector field of the pointer load can name only three pointers.
    if (NPTR != 3) begin : g_nptr_check
        $error("lpo_core supports exactly three pointers");
    end

    lpo_phase_t phase_r;
    lpo_kind_t kind_r;
    logic [7:0] w_r;
    logic n_r;
    logic z_r;
    logic [11:0] ptr_r [NPTR];
    logic second_r;
    logic [1:0] psel_r;
    logic [3:0] khi_r;
    logic [7:0] opnd_r;
    logic [7:0] res_r;
    logic dest_r;
    logic [11:0] addr_r;
    logic [11:0] addr_w;
    logic [11:0] addr_nxt;
    logic re_r;
    logic we_r;
    logic [7:0] wd_r;
    logic ill_r;
    lpo_kind_t kind_nxt;
    logic first_ok;

    // Q1 decode of the incoming word.
    always_comb begin
        kind_nxt = LPO_K_NONE;
        first_ok = 1'b0;
        if (second_r) begin
            kind_nxt = LPO_K_LDPTR;
        end else if (instr[15:8] == `LPO_OP_OR_LIT) begin
            kind_nxt = LPO_K_ORLIT;
        end else if (instr[15:10] == `LPO_OP_OR_FILE) begin
            kind_nxt = LPO_K_ORFILE;
        end else if (instr[15:6] == `LPO_OP_LDPTR1 && instr[5:4] != 2'b11) begin
            kind_nxt = LPO_K_LDPTR;
            first_ok = 1'b1;
        end
    end

    // Indexed mode uses pointer 2 as its base.
    lpo_addr_gen i_lpo_addr_gen (
        .faddr(instr[7:0]),
        .acc_sel(instr[`LPO_BIT_ACC]),
        .bank_sel(bank_select_reg),
        .ext_en(ext_en),
        .index_base(ptr_r[2]),
        .addr(addr_w),
        .indexed()
    );
    assign addr_nxt = addr_w;

    // Four-phase sequencer.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= LPO_Q1;
        end else begin
            case (phase_r)
                LPO_Q1: phase_r <= LPO_Q2;
                LPO_Q2: phase_r <= LPO_Q3;
                LPO_Q3: phase_r <= LPO_Q4;
                LPO_Q4: phase_r <= LPO_Q1;
                default: phase_r <= LPO_Q1;
            endcase
        end
    end

    // Decode and data path, one action per phase.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            kind_r <= LPO_K_NONE;
            second_r <= 1'b0;
            psel_r <= 2'b00;
            khi_r <= 4'h0;
            opnd_r <= 8'h00;
            res_r <= 8'h00;
            dest_r <= 1'b0;
            addr_r <= 12'h000;
            ill_r <= 1'b0;
        end else begin
            case (phase_r)
                LPO_Q1: begin
                    kind_r <= kind_nxt;
                    ill_r <= (kind_nxt == LPO_K_NONE);
                    dest_r <= instr[`LPO_BIT_DEST];
                    addr_r <= addr_nxt;
                    if (first_ok) begin
                        psel_r <= instr[5:4];
                        khi_r <= instr[3:0];
                    end
                end
                LPO_Q2: begin
                    if (kind_r == LPO_K_ORFILE) begin
                        opnd_r <= dmem_rdata;
                    end else begin
                        opnd_r <= instr[7:0];
                    end
                end
                LPO_Q3: begin
                    res_r <= w_r | opnd_r;
                end
                LPO_Q4: begin
                    // The second word follows only a valid first word.
                    second_r <= (kind_r == LPO_K_LDPTR) && !second_r;
                end
                default: kind_r <= LPO_K_NONE;
            endcase
        end
    end

    // Working register and flags written in Q4.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            w_r <= `LPO_W_RST;
            n_r <= 1'b0;
            z_r <= 1'b0;
        end else if (phase_r == LPO_Q4 && !second_r) begin
            if (kind_r == LPO_K_ORLIT || kind_r == LPO_K_ORFILE) begin
                n_r <= res_r[7];
                z_r <= (res_r == 8'h00);
                if (kind_r == LPO_K_ORLIT || !dest_r) begin
                    w_r <= res_r;
                end
            end
        end
    end

    // Pointer registers; no flag is touched here.
    genvar gi;
    generate
        for (gi = 0; gi < NPTR; gi++) begin : g_ptr
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    ptr_r[gi] <= `LPO_PTR_RST;
                end else if (phase_r == LPO_Q4 && kind_r == LPO_K_LDPTR && psel_r == 2'(gi)) begin
                    if (!second_r) begin
                        ptr_r[gi][11:8] <= khi_r;
                    end else if (instr[15:8] == `LPO_OP_LDPTR2) begin
                        ptr_r[gi][7:0] <= instr[7:0];
                    end
                end
            end
        end
    endgenerate

    // Data-memory strobes: read in Q2, write back in Q4.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            re_r <= 1'b0;
            we_r <= 1'b0;
            wd_r <= 8'h00;
        end else begin
            re_r <= (phase_r == LPO_Q1) && (kind_nxt == LPO_K_ORFILE) && !second_r;
            we_r <= (phase_r == LPO_Q3) && (kind_r == LPO_K_ORFILE) && dest_r
                && !second_r;
            wd_r <= w_r | opnd_r;
        end
    end

    assign phase = phase_r;
    assign wreg = w_r;
    assign flag_n = n_r;
    assign flag_z = z_r;
    assign indirect_pointer_reg0 = ptr_r[0];
    assign indirect_pointer_reg1 = ptr_r[1];
    assign indirect_pointer_reg2 = ptr_r[2];
    assign dmem_addr = addr_r;
    assign dmem_re = re_r;
    assign dmem_we = we_r;
    assign dmem_wdata = wd_r;
    assign illegal = ill_r;
endmodule : lpo_core

/* verif/lpo_core_properties.sv */
`timescale 1ns/1ps
`include "lpo_params.svh"
module lpo_core_chk
    import lpo_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Instruction and strobes.
    input wire logic [15:0] instr,
    input wire logic dmem_re,
    input wire logic dmem_we,
    input wire logic illegal,
    // Core state.
    input wire lpo_pkg::lpo_phase_t phase,
    input wire logic [7:0] wreg,
    input wire logic flag_n,
    input wire logic flag_z,
    input wire logic [11:0] indirect_pointer_reg0,
    input wire logic [11:0] indirect_pointer_reg1,
    input wire logic [11:0] indirect_pointer_reg2
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence quarters;
        phase == LPO_Q2 ##1 phase == LPO_Q3 ##1 phase == LPO_Q4 ##1 phase == LPO_Q1;
    endsequence
    sequence file_walk;
        dmem_re && !dmem_we ##1 !dmem_re && !dmem_we ##1 dmem_we == instr[`LPO_BIT_DEST];
    endsequence
    AST_PHASE_WALK: assert property (phase == LPO_Q1 |=> quarters)
        else $error("phase did not walk four quarters");
    AST_FILE_WALK: assert property (
        phase == LPO_Q1 && instr[15:10] == `LPO_OP_OR_FILE |=> file_walk)
        else $error("file access strobes out of order");
    AST_READ_Q2: assert property (dmem_re |-> phase == LPO_Q2)
        else $error("read strobe outside Q2");
    AST_W_HOLD: assert property (phase != LPO_Q4 |=> $stable(wreg))
        else $error("working register moved outside Q4");
    AST_FLAG_HOLD: assert property (
        phase != LPO_Q4 || instr[15:13] == 3'h7 |=> $stable({flag_n, flag_z}))
        else $error("flags moved");
    AST_PTR_HOLD: assert property (phase != LPO_Q4 |=>
        $stable({indirect_pointer_reg0, indirect_pointer_reg1, indirect_pointer_reg2}))
        else $error("pointer moved outside Q4");
    AST_FILE_KEEP_W: assert property (
        phase == LPO_Q4 && instr[15:9] == 7'h09 |=> $stable(wreg))
        else $error("file write changed working register");
    AST_OR_LIT: assert property (phase == LPO_Q4 && instr[15:8] == `LPO_OP_OR_LIT |=>
        wreg == ($past(wreg) | $past(instr[7:0])) && flag_n == wreg[7] && flag_z == (wreg == 8'h00))
        else $error("literal OR result wrong");
    AST_BAD_PTR: assert property (
        phase == LPO_Q1 && instr[15:6] == `LPO_OP_LDPTR1 && instr[5:4] == 2'h3
        |=> illegal [*3])
        else $error("pointer select 3 not refused");
endmodule : lpo_core_chk
bind lpo_core lpo_core_chk i_lpo_core_chk (.*);

/* verif/lpo_dmem.sv */
`timescale 1ns/1ps
module lpo_dmem (
    // Clock.
    input wire logic mclk,
    // Access port.
    input wire logic [11:0] addr,
    input wire logic re,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [4096];
    // Outside a read the bus shows garbage, so a badly timed sample is caught.
    assign rdata = re ? mem[addr] : ~mem[addr];
    always @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule : lpo_dmem

/* verif/lpo_core_bench.sv */
`timescale 1ns/1ps
module lpo_core_bench;
    import lpo_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic ext_en = 1'b0;
    logic [3:0] bank_select_reg = 4'h0;
    logic [7:0] dmem_rdata, dmem_wdata, wreg;
    logic [11:0] dmem_addr, p0, p1, p2;
    logic dmem_re, dmem_we, flag_n, flag_z, illegal;
    lpo_phase_t phase;
    int num_errors = 0;
    int samples_checked = 0;
    always #50 mclk = ~mclk;
    lpo_core i_lpo_core (.mclk(mclk), .resetn(resetn), .instr(instr), .ext_en(ext_en),
        .bank_select_reg(bank_select_reg), .dmem_rdata(dmem_rdata), .dmem_addr(dmem_addr),
        .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata), .phase(phase),
        .wreg(wreg), .flag_n(flag_n), .flag_z(flag_z), .indirect_pointer_reg0(p0),
        .indirect_pointer_reg1(p1), .indirect_pointer_reg2(p2), .illegal(illegal));
    lpo_dmem i_lpo_dmem (.mclk(mclk), .addr(dmem_addr), .re(dmem_re), .we(dmem_we),
        .wdata(dmem_wdata), .rdata(dmem_rdata));
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", what, exp, seen);
        end
    endtask : chk
    task automatic st(input logic [7:0] w, input logic n, input logic z);
        chk("w_n_z", {2'b00, wreg, flag_n, flag_z}, {2'b00, w, n, z});
    endtask : st
    // One instruction cycle is four clocks; the word is held for all of them.
    task automatic run(input logic [15:0] w);
        instr <= w;
        repeat (4) @(posedge mclk);
        #1;
    endtask : run
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        run(16'h0900);
        st(8'h00, 1'b0, 1'b1);
        run(16'h0912);
        st(8'h12, 1'b0, 1'b0);
        ext_en <= 1'b1;
        bank_select_reg <= 4'h3;
        i_lpo_dmem.mem[12'hf70] = 8'h81;
        run(16'h1270);
        st(8'h12, 1'b1, 1'b0);
        chk("mem_f70", i_lpo_dmem.mem[12'hf70], 12'h093);
        i_lpo_dmem.mem[12'h340] = 8'h21;
        run(16'h1140);
        st(8'h33, 1'b0, 1'b0);
        chk("mem_340", i_lpo_dmem.mem[12'h340], 12'h021);
        run(16'hee23);
        chk("ptr2", p2, 12'h300);
        run(16'hf0ab);
        chk("ptr2", p2, 12'h3ab);
        st(8'h33, 1'b0, 1'b0);
        i_lpo_dmem.mem[12'h3b0] = 8'h44;
        run(16'h1205);
        chk("mem_3b0", i_lpo_dmem.mem[12'h3b0], 12'h077);
        st(8'h33, 1'b0, 1'b0);
        ext_en <= 1'b0;
        i_lpo_dmem.mem[12'h005] = 8'h80;
        run(16'h1005);
        st(8'hb3, 1'b1, 1'b0);
        run(16'hee15);
        run(16'h0000);
        chk("ptr1", p1, 12'h500);
        chk("illegal", {11'h000, illegal}, 12'h000);
        run(16'hee30);
        chk("ptr0", p0, 12'h000);
        chk("illegal", {11'h000, illegal}, 12'h001);
        run(16'hee0f);
        run(16'hf0ff);
        chk("ptr0", p0, 12'hfff);
        chk("illegal", {11'h000, illegal}, 12'h000);
        wrap_up();
    end
endmodule : lpo_core_bench
